// File: vc_resource_config_regs_defines.vh
`ifndef VC_RESOURCE_CONFIG_REGS_DEFINES_VH
`define VC_RESOURCE_CONFIG_REGS_DEFINES_VH

// Printed byte offsets in configuration space
`define CHAN0_RESOURCE_STATUS_OFFSET 12'h18A
`define CHAN1_RESOURCE_CAPABILITY_OFFSET 12'h18C
`define CHAN1_RESOURCE_CONTROL_OFFSET 12'h190

// Dword that holds the 16-bit status register in its upper half
`define CHAN0_STATUS_DWORD_OFFSET 12'h188
`define CHAN0_STATUS_LANE_SHIFT 16

// Reset values
`define CHAN0_RESOURCE_STATUS_RESET 16'h0000
`define CHAN1_RESOURCE_CAPABILITY_RESET 32'h00000000
`define CHAN1_RESOURCE_CONTROL_RESET 32'h01000000

// Channel zero status fields
`define NEGOTIATION_PENDING_BIT 1
`define ARB_TABLE_STATUS_BIT 0

// Second channel capability fields
`define ARB_TABLE_OFFSET_MSB 31
`define ARB_TABLE_OFFSET_LSB 24
`define MAX_TIME_SLOTS_MSB 22
`define MAX_TIME_SLOTS_LSB 16
`define REJECT_SNOOP_BIT 15
`define UNDEFINED_BIT 14
`define ARB_CAPABILITY_MSB 7
`define ARB_CAPABILITY_LSB 0

// Second channel control fields
`define CHANNEL_ENABLE_BIT 31
`define CHANNEL_IDENTIFIER_MSB 26
`define CHANNEL_IDENTIFIER_LSB 24
`define ARB_SELECT_MSB 19
`define ARB_SELECT_LSB 17
`define LOAD_ARB_TABLE_BIT 16
`define TRAFFIC_CLASS_MAP_UPPER_MSB 7
`define TRAFFIC_CLASS_MAP_UPPER_LSB 1
`define TRAFFIC_CLASS_MAP_ZERO_BIT 0

// Field reset values
`define CHANNEL_ENABLE_RESET 1'h0
`define CHANNEL_IDENTIFIER_RESET 3'h1
`define TRAFFIC_CLASS_MAP_UPPER_RESET 7'h00

// Byte lanes that carry the writable control fields
`define CTL_LANE_ENABLE_ID 3
`define CTL_LANE_TC_MAP 0

`endif

// File: vc_resource_config_regs.v
`timescale 1ns/1ps
`include "vc_resource_config_regs_defines.vh"
module vc_resource_config_regs (
	input wire i_clk, // 50 MHz clock
	input wire i_sys_rst, // Synchronous reset, active high
	input wire [11:0] i_cfg_addr, // Config byte address, dword aligned
	input wire i_cfg_rd, // Config read strobe
	input wire i_cfg_wr, // Config write strobe
	input wire [3:0] i_cfg_be, // Config byte enables
	input wire [31:0] i_cfg_wdata, // Config write data
	output reg [31:0] o_cfg_rdata, // Config read data, registered
	output reg o_cfg_rvalid, // Read data valid pulse
	output reg o_cfg_wack, // Write done pulse
	output wire o_channel_enable, // Second channel enabled
	output wire [2:0] o_channel_identifier, // Second channel identifier
	output wire [7:0] o_traffic_class_map // Classes mapped to second channel
);

	// Full byte addresses of the decoded dwords; bits 1:0 drop out of the compare
	localparam [11:0] status_dword_addr = `CHAN0_STATUS_DWORD_OFFSET;
	localparam [11:0] cap_dword_addr = `CHAN1_RESOURCE_CAPABILITY_OFFSET;
	localparam [11:0] ctl_dword_addr = `CHAN1_RESOURCE_CONTROL_OFFSET;

	// Number of writable traffic class bits above class zero
	localparam tc_upper_width = 7;

	// Stored fields of the second channel's control register
	reg channel_enable_reg;
	reg channel_enable_next;
	reg [2:0] channel_identifier_reg;
	reg [2:0] channel_identifier_next;
	reg [6:0] traffic_class_map_upper_reg;
	wire [6:0] traffic_class_map_upper_next;

	// Read data before it is captured
	reg [31:0] rdata_next;

	// Address decode
	wire [9:0] dword_sel;
	wire hit_status;
	wire hit_cap;
	wire hit_ctl;

	// Write qualifiers per byte lane of the control dword
	wire ctl_write;
	wire lane_enable_id_write;
	wire lane_tc_map_write;

	// Channel zero status fields
	wire negotiation_pending;
	wire arb_table_status;
	wire [13:0] status_reserved;
	wire [15:0] status_value;

	// Second channel capability fields
	wire [7:0] arb_table_offset;
	wire cap_reserved_hi;
	wire [6:0] max_time_slots;
	wire reject_snoop;
	wire undefined_bit;
	wire [5:0] cap_reserved_lo;
	wire [7:0] arb_capability;
	wire [31:0] cap_value;

	// Second channel control fields that software cannot change
	wire [2:0] arb_select;
	wire load_arb_table;
	wire traffic_class_map_zero;
	wire [31:0] ctl_value;

	// Decode on the dword index; byte lanes pick the field inside it
	assign dword_sel = i_cfg_addr[11:2];
	assign hit_status = (dword_sel == status_dword_addr[11:2]);
	assign hit_cap = (dword_sel == cap_dword_addr[11:2]);
	assign hit_ctl = (dword_sel == ctl_dword_addr[11:2]);

	// A write reaches a control field only through its own byte lane
	assign ctl_write = i_cfg_wr & hit_ctl;
	assign lane_enable_id_write = ctl_write & i_cfg_be[`CTL_LANE_ENABLE_ID];
	assign lane_tc_map_write = ctl_write & i_cfg_be[`CTL_LANE_TC_MAP];

	// No link negotiates channels here, so nothing is ever pending
	assign negotiation_pending = 1'b0;

	// Port arbitration is absent, so its table can never be out of step
	assign arb_table_status = 1'b0;
	assign status_reserved = 14'h0000;

	// Status image, sixteen bits wide
	assign status_value = {status_reserved,
		negotiation_pending,
		arb_table_status};

	// Capability fields are all constants; nothing here describes arbitration
	assign arb_table_offset = 8'h00;
	assign cap_reserved_hi = 1'b0;
	assign max_time_slots = 7'h00;
	assign reject_snoop = 1'b0;

	// Tied low so repeated reads agree; software must still not rely on it
	assign undefined_bit = 1'b0;
	assign cap_reserved_lo = 6'h00;
	assign arb_capability = 8'h00;

	// Capability image in field order, most significant first
	assign cap_value = {arb_table_offset,
		cap_reserved_hi,
		max_time_slots,
		reject_snoop,
		undefined_bit,
		cap_reserved_lo,
		arb_capability};

	// Arbitration select and table load have no hardware behind them
	assign arb_select = 3'h0;
	assign load_arb_table = 1'b0;

	// Class zero always stays on channel zero
	assign traffic_class_map_zero = 1'b0;

	// Control read image: only the stored fields are live, the rest is tied zero
	assign ctl_value = {channel_enable_reg,
		4'h0,
		channel_identifier_reg,
		4'h0,
		arb_select,
		load_arb_table,
		8'h00,
		traffic_class_map_upper_reg,
		traffic_class_map_zero};

	// Outputs that steer the channel logic come straight from the flops, save class zero, which is tied low
	assign o_channel_enable = channel_enable_reg;
	assign o_channel_identifier = channel_identifier_reg;
	assign o_traffic_class_map = {traffic_class_map_upper_reg, traffic_class_map_zero};

	// Lane three carries the enable and the identifier together
	always @* begin
		channel_enable_next = channel_enable_reg;
		channel_identifier_next = channel_identifier_reg;
		if (lane_enable_id_write) begin
			channel_enable_next = i_cfg_wdata[`CHANNEL_ENABLE_BIT];
			channel_identifier_next =
				i_cfg_wdata[`CHANNEL_IDENTIFIER_MSB:`CHANNEL_IDENTIFIER_LSB];
		end
	end

	// Each class bit above class zero either takes its write data bit or keeps its value
	genvar tc_idx;
	generate
		for (tc_idx = 0; tc_idx < tc_upper_width; tc_idx = tc_idx + 1) begin : g_tc_map
			assign traffic_class_map_upper_next[tc_idx] = lane_tc_map_write ?
				i_cfg_wdata[`TRAFFIC_CLASS_MAP_UPPER_LSB + tc_idx] :
				traffic_class_map_upper_reg[tc_idx];
		end
	endgenerate

	// Read mux; unmapped dwords and the lower half of the status dword return zero
	always @* begin
		rdata_next = 32'h00000000;
		if (hit_status) begin
			rdata_next = {status_value, 16'h0000};
		end else if (hit_cap) begin
			rdata_next = cap_value;
		end else if (hit_ctl) begin
			rdata_next = ctl_value;
		end
	end

	// Field registers; a write and a read in one cycle returns the older value
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			channel_enable_reg <= `CHANNEL_ENABLE_RESET;
			channel_identifier_reg <= `CHANNEL_IDENTIFIER_RESET;
			traffic_class_map_upper_reg <= `TRAFFIC_CLASS_MAP_UPPER_RESET;
		end else begin
			channel_enable_reg <= channel_enable_next;
			channel_identifier_reg <= channel_identifier_next;
			traffic_class_map_upper_reg <= traffic_class_map_upper_next;
		end
	end

	// Bus answers; read data is held until the next read so it is stable for sampling
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_cfg_rdata <= 32'h00000000;
			o_cfg_rvalid <= 1'b0;
			o_cfg_wack <= 1'b0;
		end else begin
			// Every write is acknowledged, even one that lands on nothing
			o_cfg_rvalid <= i_cfg_rd;
			o_cfg_wack <= i_cfg_wr;
			if (i_cfg_rd) begin
				o_cfg_rdata <= rdata_next;
			end
		end
	end

endmodule

// File: vc_resource_config_regs_assertions.sv
`timescale 1ns/1ps
module vc_resource_config_regs_assertions (
	input wire i_clk, input wire i_sys_rst, input wire [11:0] i_cfg_addr, input wire i_cfg_rd, input wire i_cfg_wr,
	input wire [3:0] i_cfg_be, input wire [31:0] i_cfg_wdata, input wire [31:0] o_cfg_rdata, input wire o_cfg_rvalid,
	input wire o_cfg_wack, input wire o_channel_enable, input wire [2:0] o_channel_identifier,
	input wire [7:0] o_traffic_class_map
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Control dword write and a read of dword d, the two steps the checks build on
	sequence s_ctl_wr; i_cfg_wr && i_cfg_addr[11:2] == 10'h064; endsequence
	sequence s_rd(d); i_cfg_rd && i_cfg_addr[11:2] == d; endsequence
	a_enable_write: assert property (s_ctl_wr ##0 i_cfg_be[3] |=> o_channel_enable == $past(i_cfg_wdata[31]))
		else $error("enable not loaded");
	a_ident_write: assert property (s_ctl_wr ##0 i_cfg_be[3] |=> o_channel_identifier == $past(i_cfg_wdata[26:24]))
		else $error("identifier not loaded");
	a_map_write: assert property (s_ctl_wr ##0 i_cfg_be[0] |=> o_traffic_class_map[7:1] == $past(i_cfg_wdata[7:1]))
		else $error("class map not loaded");
	a_map_zero: assert property (o_traffic_class_map[0] == 1'b0) else $error("class zero mapped");
	a_status_zero: assert property (s_rd(10'h062) |=> o_cfg_rvalid && o_cfg_rdata == 32'h00000000)
		else $error("status not zero");
	a_cap_zero: assert property (s_rd(10'h063) |=> o_cfg_rvalid && (o_cfg_rdata & 32'hFFFFBFFF) == 32'h00000000)
		else $error("capability not zero");
	// Read gives pre-write field values, so compare with last cycle's outputs
	a_ctl_image: assert property (s_rd(10'h064) |=> o_cfg_rdata == {$past(o_channel_enable), 4'h0,
		$past(o_channel_identifier), 16'h0000, $past(o_traffic_class_map)}) else $error("control image wrong");
	a_fields_hold: assert property (!(i_cfg_wr && i_cfg_addr[11:2] == 10'h064) |=>
		$stable({o_channel_enable, o_channel_identifier, o_traffic_class_map})) else $error("fields moved");
endmodule

// File: vc_resource_config_regs_tb_top.sv
`timescale 1ns/1ps
module vc_resource_config_regs_tb_top;
	logic i_clk = 1'b0, i_sys_rst = 1'b1, i_cfg_rd = 1'b0, i_cfg_wr = 1'b0, o_cfg_rvalid, o_cfg_wack, o_channel_enable;
	logic [11:0] i_cfg_addr = 12'h000;
	logic [3:0] i_cfg_be = 4'h0;
	logic [31:0] i_cfg_wdata = 32'h00000000, o_cfg_rdata;
	logic [2:0] o_channel_identifier;
	logic [7:0] o_traffic_class_map;
	int mismatches = 0, checked = 0;
	vc_resource_config_regs vc_resource_config_regs_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cfg_addr(i_cfg_addr),
		.i_cfg_rd(i_cfg_rd), .i_cfg_wr(i_cfg_wr), .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata),
		.o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid), .o_cfg_wack(o_cfg_wack),
		.o_channel_enable(o_channel_enable), .o_channel_identifier(o_channel_identifier),
		.o_traffic_class_map(o_traffic_class_map));
	// 50 MHz clock
	always #10 i_clk = ~i_clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task fields(input logic [31:0] exp);
		chk({o_channel_enable, o_channel_identifier, o_traffic_class_map}, exp);
	endtask
	// One-cycle strobe; the answer pulse is looked at just after the next edge
	task wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
		@(posedge i_clk) {i_cfg_wr, i_cfg_addr, i_cfg_be, i_cfg_wdata} <= {1'b1, a, b, d};
		@(posedge i_clk) i_cfg_wr <= 1'b0;
		#1 chk(o_cfg_wack, 1);
	endtask
	// The mask hides bits whose value software may not rely on
	task rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF);
		@(posedge i_clk) {i_cfg_rd, i_cfg_addr} <= {1'b1, a};
		@(posedge i_clk) i_cfg_rd <= 1'b0;
		#1 chk({o_cfg_rvalid, o_cfg_rdata & m}, {1'b1, exp});
	endtask
	task t_defaults;
		fields(32'h100);
		rd(12'h188, 32'h00000000);
		rd(12'h18C, 32'h00000000, 32'hFFFFBFFF);
		rd(12'h190, 32'h01000000);
	endtask
	// All ones must leave read-only and reserved bits, and class zero, clear
	task t_all_ones;
		wr(12'h190, 4'hF, 32'hFFFFFFFF);
		fields(32'hFFE);
		rd(12'h190, 32'h870000FE);
	endtask
	task t_lanes;
		wr(12'h190, 4'h1, 32'hFF000000);
		fields(32'hF00);
		wr(12'h190, 4'h8, 32'h020000FF);
		fields(32'h200);
	endtask
	task t_read_only;
		wr(12'h188, 4'hF, 32'hFFFFFFFF);
		wr(12'h18C, 4'hF, 32'hFFFFFFFF);
		wr(12'h1A0, 4'hF, 32'hFFFFFFFF);
		rd(12'h188, 32'h00000000);
		rd(12'h18C, 32'h00000000, 32'hFFFFBFFF);
		rd(12'h1A0, 32'h00000000);
		fields(32'h200);
	endtask
	task wrap_up;
		if (mismatches == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Main sequence; reset held for two edges
	initial begin
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		#1 t_defaults;
		t_all_ones;
		t_lanes;
		t_read_only;
		wrap_up;
	end
	// The run needs well under a hundred cycles
	initial begin
		#20000 mismatches++;
		wrap_up;
	end
endmodule
bind vc_resource_config_regs vc_resource_config_regs_assertions chk_inst (.*);
